// File: rtl/mcs_consts.svh
`ifndef MCS_CONSTS_SVH
`define MCS_CONSTS_SVH
// register byte offsets
`define MCS_OFS_KEY_SCAN 8'h00
`define MCS_OFS_KEY_SENSE 8'h04
`define MCS_OFS_CARRIER_CTL 8'h08
`define MCS_OFS_PORT_MODE 8'h0c
`define MCS_OFS_CORE_STAT 8'h10
`define MCS_OFS_EXEC 8'h14
`define MCS_OFS_MEM_INDEX 8'h18
`define MCS_OFS_MEM_PAIR 8'h1c
`define MCS_OFS_TABLE_PTR 8'h20
`define MCS_OFS_PC 8'h24
`define MCS_OFS_FETCH 8'h28
`define MCS_OFS_TABLE_DATA 8'h2c
`define MCS_OFS_LOAD_ADDR 8'h30
`define MCS_OFS_LOAD_DATA 8'h34
// reset values
`define MCS_RST_KEY_SCAN 8'hff
`define MCS_RST_CARRIER_CTL 8'h03
`define MCS_RST_PORT_MODE 8'h26
`define MCS_RST_PAIR_ZERO 8'h00
`define MCS_RST_PC 10'h000
// program space
`define MCS_TEST_BASE 10'h3ea
`define MCS_FOLD_ADDR 10'h000
// field positions
`define MCS_CTL_TP_LO 4
`define MCS_CTL_TP_HI 5
`define MCS_MODE_S0 0
`define MCS_MODE_KEY_OUT 1
`define MCS_MODE_S1_OUT 2
`define MCS_ACC_MSB 3
`define MCS_PAIR_LAST 4'hf
`define MCS_PAIR_FIRST 4'h0
`define MCS_NIB_ALL 4'hf
`define MCS_PAD_BITS 2'b11
`endif

// File: rtl/mcs_pkg.sv
// Purpose: types shared by the core state block
// Assumes: constants come from mcs_consts.svh
// Notes: operation codes are the low nibble of the exec register
package mcs_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } mcs_apb_req_type;
   typedef enum logic [3:0] {
      MCS_OP_NOP = 4'h0,
      MCS_OP_AND = 4'h1,
      MCS_OP_OR = 4'h2,
      MCS_OP_XOR = 4'h3,
      MCS_OP_RL = 4'h4,
      MCS_OP_RLZ = 4'h5,
      MCS_OP_INC = 4'h6,
      MCS_OP_SET_CARRY_ADD_OP = 4'h7,
      MCS_OP_MOVI = 4'h8,
      MCS_OP_IN = 4'h9,
      MCS_OP_TEST_STATUS_OP = 4'ha,
      MCS_OP_HALT = 4'hb,
      MCS_OP_LDM = 4'hc,
      MCS_OP_STM = 4'hd,
      MCS_OP_CALL = 4'he,
      MCS_OP_STEP = 4'hf
   } mcs_op_type;
   typedef enum logic [1:0] {
      MCS_RUN = 2'b01,
      MCS_STANDBY = 2'b10
   } mcs_state_type;
endpackage

// File: rtl/mcs_core.sv
// Purpose: core state of a 4-bit controller: program store, pairs, flags
// Assumes: apb slave, one clock pclk, presetn async active low
// Notes: exec register fires one operation per write in the run state, none in standby
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`include "mcs_consts.svh"
module mcs_core #(
   parameter int PROG_DEPTH = 1024,
   parameter int PROG_MOUNT = 1002
) (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire mcs_pkg::mcs_apb_req_type apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // key scan pins
   input wire logic [7:0] key_scan_pins_in,
   output logic [7:0] key_scan_pins_out,
   output logic key_scan_pins_oe_n,
   // key return and sense pins
   input wire logic [3:0] key_return_pins,
   input wire logic sense_zero_pin,
   input wire logic sense_one_indicator_pin_in,
   output logic sense_one_indicator_pin_out,
   output logic sense_one_indicator_pin_oe_n,
   // timer and core state
   input wire logic timer_count_zero,
   output logic [9:0] fetch_word,
   output logic standby
);
   import mcs_pkg::*;

   // ==========================================
   // pin synchronisers
   // ==========================================
   localparam int SYNW = 14;
   logic [SYNW-1:0] pin_raw;
   logic [SYNW-1:0] sync1_q;
   logic [SYNW-1:0] sync2_q;
   logic [SYNW-1:0] sync3_q;
   logic [SYNW-1:0] pin_q;
   assign pin_raw = {sense_one_indicator_pin_in, sense_zero_pin,
                     key_return_pins, key_scan_pins_in};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end
   // a bit moves only once two stages agree, filtering one-cycle glitches
   genvar gi;
   generate
      for (gi = 0; gi < SYNW; gi++) begin : g_filt
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_q[gi] <= 1'b0;
            end else if (sync2_q[gi] == sync3_q[gi]) begin
               pin_q[gi] <= sync3_q[gi];
            end
         end
      end
   endgenerate
   logic [7:0] key_scan_lvl;
   logic [3:0] key_ret_lvl;
   logic s0_lvl;
   logic s1_lvl;
   assign key_scan_lvl = pin_q[7:0];
   assign key_ret_lvl = pin_q[11:8];
   assign s0_lvl = pin_q[12];
   assign s1_lvl = pin_q[13];

   // ==========================================
   // apb decode
   // ==========================================
   logic acc_phase;
   logic wr_fire;
   logic rd_take;
   logic [7:0] a;
   assign a = apb_req.paddr;
   assign acc_phase = apb_req.psel & apb_req.penable;
   assign wr_fire = acc_phase & pready & apb_req.pwrite;
   assign rd_take = acc_phase & ~pready;
   logic hit_scan, hit_sense, hit_ctl, hit_mode, hit_stat, hit_exec;
   logic hit_idx, hit_pair, hit_tp, hit_pc, hit_fetch, hit_tdat;
   logic hit_ladr, hit_ldat, hit_any;
   assign hit_scan = (a == `MCS_OFS_KEY_SCAN);
   assign hit_sense = (a == `MCS_OFS_KEY_SENSE);
   assign hit_ctl = (a == `MCS_OFS_CARRIER_CTL);
   assign hit_mode = (a == `MCS_OFS_PORT_MODE);
   assign hit_stat = (a == `MCS_OFS_CORE_STAT);
   assign hit_exec = (a == `MCS_OFS_EXEC);
   assign hit_idx = (a == `MCS_OFS_MEM_INDEX);
   assign hit_pair = (a == `MCS_OFS_MEM_PAIR);
   assign hit_tp = (a == `MCS_OFS_TABLE_PTR);
   assign hit_pc = (a == `MCS_OFS_PC);
   assign hit_fetch = (a == `MCS_OFS_FETCH);
   assign hit_tdat = (a == `MCS_OFS_TABLE_DATA);
   assign hit_ladr = (a == `MCS_OFS_LOAD_ADDR);
   assign hit_ldat = (a == `MCS_OFS_LOAD_DATA);
   assign hit_any = hit_scan | hit_sense | hit_ctl | hit_mode | hit_stat
                  | hit_exec | hit_idx | hit_pair | hit_tp | hit_pc
                  | hit_fetch | hit_tdat | hit_ladr | hit_ldat;

   // ==========================================
   // state registers
   // ==========================================
   logic [7:0] scan_latch_q, scan_latch_d;
   logic [7:0] ctl_q, ctl_d;
   logic [7:0] mode_q, mode_d;
   logic [3:0] idx_q;
   logic [9:0] pc_q, pc_d;
   logic [9:0] ladr_q;
   logic [7:0] pair_zero_q, pair_zero_d;
   logic [1:0] ras_hi_q;
   logic [3:0] acc_q, acc_d;
   logic carry_q, carry_d;
   logic status_q, status_d;
   mcs_state_type state_q, state_d;
   logic [7:0] pair_mem [1:15];
   logic [9:0] prog_mem [0:PROG_DEPTH-1];

   // ==========================================
   // program store
   // ==========================================
   function automatic logic [9:0] fold(input logic [9:0] ad);
      if (32'(ad) >= PROG_MOUNT || ad >= `MCS_TEST_BASE) begin
         fold = `MCS_FOLD_ADDR;
      end else begin
         fold = ad;
      end
   endfunction
   logic [9:0] table_ptr;
   logic [9:0] fetch_d;
   logic [9:0] table_word;
   assign table_ptr = {ctl_q[`MCS_CTL_TP_HI], ctl_q[`MCS_CTL_TP_LO], pair_zero_q};
   assign fetch_d = prog_mem[fold(pc_q)];
   assign table_word = prog_mem[fold(table_ptr)];
   always_ff @(posedge pclk) begin
      if (wr_fire && hit_ldat) begin
         prog_mem[ladr_q] <= apb_req.pwdata[9:0];
      end
   end

   // ==========================================
   // operation decode
   // ==========================================
   logic exec_fire;
   mcs_op_type op;
   logic [3:0] opnd;
   assign exec_fire = wr_fire & hit_exec & (state_q == MCS_RUN);
   assign op = mcs_op_type'(apb_req.pwdata[3:0]);
   assign opnd = apb_req.pwdata[7:4];
   logic [7:0] cur_pair;
   assign cur_pair = (idx_q == `MCS_PAIR_FIRST) ? pair_zero_q : pair_mem[idx_q];
   logic key_hi, sense_hi, s0_in_mode, cond, wake;
   assign s0_in_mode = mode_q[`MCS_MODE_S0];
   assign key_hi = |key_ret_lvl;
   // off mode blocks the s0 path so a floating pin cannot satisfy a test
   assign sense_hi = (s0_lvl & s0_in_mode) | s1_lvl;
   always_comb begin
      case (opnd[2:0])
         3'h0, 3'h3, 3'h6: cond = key_hi;
         3'h5: cond = timer_count_zero;
         default: cond = 1'b0;
      endcase
      if (opnd[3]) begin
         cond = cond | sense_hi;
      end
   end
   assign wake = key_hi | timer_count_zero;

   // ==========================================
   // alu and flags
   // ==========================================
   logic [4:0] inc_sum;
   assign inc_sum = {1'b0, acc_q} + 5'h01;
   always_comb begin
      acc_d = acc_q;
      carry_d = carry_q;
      status_d = status_q;
      state_d = state_q;
      if (state_q == MCS_STANDBY && wake) begin
         state_d = MCS_RUN;
         status_d = 1'b1;
      end
      if (exec_fire) begin
         case (op)
            MCS_OP_AND: begin
               acc_d = acc_q & opnd;
               carry_d = acc_q[`MCS_ACC_MSB] & opnd[`MCS_ACC_MSB];
            end
            MCS_OP_XOR: begin
               acc_d = acc_q ^ opnd;
               carry_d = acc_q[`MCS_ACC_MSB] & opnd[`MCS_ACC_MSB];
            end
            MCS_OP_OR: begin
               acc_d = acc_q | opnd;
               carry_d = 1'b0;
            end
            MCS_OP_RL: begin
               acc_d = {acc_q[2:0], acc_q[`MCS_ACC_MSB]};
               carry_d = acc_q[`MCS_ACC_MSB];
            end
            MCS_OP_RLZ: begin
               acc_d = {acc_q[2:0], 1'b0};
               carry_d = acc_q[`MCS_ACC_MSB];
            end
            MCS_OP_INC, MCS_OP_SET_CARRY_ADD_OP: begin
               acc_d = inc_sum[3:0];
               carry_d = (acc_q == `MCS_NIB_ALL);
            end
            MCS_OP_MOVI: begin
               acc_d = opnd;
               carry_d = 1'b0;
            end
            MCS_OP_IN: begin
               acc_d = key_ret_lvl;
               carry_d = 1'b0;
            end
            MCS_OP_LDM: begin
               acc_d = opnd[0] ? cur_pair[7:4] : cur_pair[3:0];
               carry_d = 1'b0;
            end
            MCS_OP_TEST_STATUS_OP: begin
               status_d = cond;
            end
            MCS_OP_HALT: begin
               if (wake) begin
                  status_d = 1'b1;
               end else if (status_q) begin
                  status_d = 1'b0;
               end else begin
                  state_d = MCS_STANDBY;
               end
            end
            default: begin
            end
         endcase
      end
   end
   always_ff @(posedge pclk) begin
      acc_q <= acc_d;
   end

   // ==========================================
   // pair memory and stack
   // ==========================================
   logic pair_wr;
   logic [7:0] pair_wdata;
   logic call_fire;
   assign call_fire = exec_fire & (op == MCS_OP_CALL);
   always_comb begin
      pair_wr = 1'b0;
      pair_wdata = cur_pair;
      if (wr_fire && hit_pair) begin
         pair_wr = 1'b1;
         pair_wdata = apb_req.pwdata[7:0];
      end else if (exec_fire && op == MCS_OP_STM) begin
         pair_wr = 1'b1;
         pair_wdata = opnd[0] ? {acc_q, cur_pair[3:0]} : {cur_pair[7:4], acc_q};
      end
   end
   always_comb begin
      pair_zero_d = pair_zero_q;
      if (pair_wr && idx_q == `MCS_PAIR_FIRST) begin
         pair_zero_d = pair_wdata;
      end
   end
   // pairs one to fifteen keep contents across reset
   always_ff @(posedge pclk) begin
      if (call_fire) begin
         pair_mem[`MCS_PAIR_LAST] <= pc_q[7:0];
         ras_hi_q <= pc_q[9:8];
      end else if (pair_wr && idx_q != `MCS_PAIR_FIRST) begin
         pair_mem[idx_q] <= pair_wdata;
      end
   end

   // ==========================================
   // program counter and port registers
   // ==========================================
   always_comb begin
      pc_d = pc_q;
      if (wr_fire && hit_pc) begin
         pc_d = fold(apb_req.pwdata[9:0]);
      end else if (exec_fire && op == MCS_OP_CALL) begin
         pc_d = fold({opnd, pc_q[5:0]});
      end else if (exec_fire && op == MCS_OP_STEP) begin
         pc_d = fold(pc_q + 10'h001);
      end
   end
   assign scan_latch_d = (wr_fire && hit_scan) ? apb_req.pwdata[7:0] : scan_latch_q;
   assign ctl_d = (wr_fire && hit_ctl) ? {2'b00, apb_req.pwdata[5:0]} : ctl_q;
   assign mode_d = (wr_fire && hit_mode) ? {2'b00, apb_req.pwdata[5:4], 1'b0, apb_req.pwdata[2:0]} : mode_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_latch_q <= `MCS_RST_KEY_SCAN;
         ctl_q <= `MCS_RST_CARRIER_CTL;
         mode_q <= `MCS_RST_PORT_MODE;
         pair_zero_q <= `MCS_RST_PAIR_ZERO;
         pc_q <= `MCS_RST_PC;
         idx_q <= '0;
         ladr_q <= '0;
         carry_q <= 1'b0;
         status_q <= 1'b0;
         state_q <= MCS_RUN;
      end else begin
         scan_latch_q <= scan_latch_d;
         ctl_q <= ctl_d;
         mode_q <= mode_d;
         pair_zero_q <= pair_zero_d;
         pc_q <= pc_d;
         carry_q <= carry_d;
         status_q <= status_d;
         state_q <= state_d;
         if (wr_fire && hit_idx) begin
            idx_q <= apb_req.pwdata[3:0];
         end
         if (wr_fire && hit_ladr) begin
            ladr_q <= apb_req.pwdata[9:0];
         end
      end
   end

   // ==========================================
   // read mux and outputs
   // ==========================================
   logic key_out_mode;
   logic [7:0] scan_rd, sense_rd;
   logic [31:0] rd_d;
   assign key_out_mode = mode_q[`MCS_MODE_KEY_OUT];
   assign scan_rd = key_out_mode ? scan_latch_q : key_scan_lvl;
   assign sense_rd = {key_ret_lvl, s1_lvl, s0_in_mode ? s0_lvl : 1'b1, `MCS_PAD_BITS};
   always_comb begin
      rd_d = '0;
      if (hit_scan) rd_d[7:0] = scan_rd;
      if (hit_sense) rd_d[7:0] = sense_rd;
      if (hit_ctl) rd_d[7:0] = ctl_q;
      if (hit_mode) rd_d[7:0] = mode_q;
      if (hit_stat) rd_d[7:0] = {1'b0, state_q == MCS_STANDBY, status_q, carry_q, acc_q};
      if (hit_idx) rd_d[3:0] = idx_q;
      if (hit_pair) rd_d[7:0] = cur_pair;
      if (hit_tp) rd_d[9:0] = table_ptr;
      if (hit_pc) rd_d[9:0] = pc_q;
      if (hit_fetch) rd_d[9:0] = fetch_d;
      if (hit_tdat) rd_d[9:0] = table_word;
      if (hit_ladr) rd_d[9:0] = ladr_q;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         key_scan_pins_out <= `MCS_RST_KEY_SCAN;
         key_scan_pins_oe_n <= 1'b0;
         sense_one_indicator_pin_out <= 1'b1;
         sense_one_indicator_pin_oe_n <= 1'b0;
         fetch_word <= '0;
         standby <= 1'b0;
      end else begin
         // one wait state keeps the read mux off the critical path
         pready <= acc_phase & ~pready;
         pslverr <= acc_phase & ~pready & ~hit_any;
         if (rd_take && !apb_req.pwrite) begin
            prdata <= rd_d;
         end
         key_scan_pins_out <= scan_latch_d;
         key_scan_pins_oe_n <= ~mode_d[`MCS_MODE_KEY_OUT];
         sense_one_indicator_pin_out <= 1'b1;
         sense_one_indicator_pin_oe_n <= ~mode_d[`MCS_MODE_S1_OUT];
         fetch_word <= fetch_d;
         standby <= (state_d == MCS_STANDBY);
      end
   end
endmodule

// File: tb/mcs_core_props.sv
// Purpose: port level checks for the core state block
// Assumes: one clock pclk, presetn async active low
// Notes: bound onto mcs_core from the bench top
module mcs_core_props (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire mcs_pkg::mcs_apb_req_type apb_req,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins and core state
   input wire logic [7:0] key_scan_pins_out,
   input wire logic key_scan_pins_oe_n,
   input wire logic [3:0] key_return_pins,
   input wire logic timer_count_zero,
   input wire logic standby
);
   import mcs_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================
   // expected port state from completed writes
   wire logic done = apb_req.psel & apb_req.penable & pready;
   wire logic wr_done = done & apb_req.pwrite;
   wire logic halt_wr = wr_done & (apb_req.paddr == 8'h14) & (apb_req.pwdata[3:0] == 4'hb);
   // key pins pass the same three-stage agree filter as inside the block
   logic [3:0] kr1_q;
   logic [3:0] kr2_q;
   logic [3:0] kr3_q;
   logic [3:0] kr_lvl_q;
   wire logic [3:0] kr_moving = kr2_q ^ kr3_q;
   wire logic wake = (|kr_lvl_q) | timer_count_zero;
   logic [7:0] latch_q;
   logic dir_q;
   wire logic [7:0] latch_d = (wr_done && apb_req.paddr == 8'h00) ? apb_req.pwdata[7:0] : latch_q;
   wire logic dir_d = (wr_done && apb_req.paddr == 8'h0c) ? !apb_req.pwdata[1] : dir_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= 8'hff;
         dir_q <= 1'b0;
         kr1_q <= 4'h0;
         kr2_q <= 4'h0;
         kr3_q <= 4'h0;
         kr_lvl_q <= 4'h0;
      end else begin
         latch_q <= latch_d;
         dir_q <= dir_d;
         kr1_q <= key_return_pins;
         kr2_q <= kr1_q;
         kr3_q <= kr2_q;
         kr_lvl_q <= (kr3_q & ~kr_moving) | (kr_lvl_q & kr_moving);
      end
   end
   // ==========================================
   // properties
   property p_ready_wait;
      $rose(apb_req.psel & apb_req.penable) |-> !pready ##1 pready;
   endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait state");
   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
   property p_err_ready;
      pslverr |-> pready && apb_req.psel;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("pslverr outside a transfer end");
   property p_unmapped;
      done && apb_req.paddr > 8'h34 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_key_latch;
      $stable(latch_q) && $past(latch_q) == $past(latch_q, 2) |-> key_scan_pins_out == latch_q;
   endproperty
   a_key_latch: assert property (p_key_latch) else $error("key latch differs from last write");
   property p_key_dir;
      $stable(dir_q) && $past(dir_q) == $past(dir_q, 2) |-> key_scan_pins_oe_n == dir_q;
   endproperty
   a_key_dir: assert property (p_key_dir) else $error("key direction differs from mode bit");
   property p_standby_entry;
      $rose(standby) |-> $past(halt_wr) || $past(halt_wr, 2);
   endproperty
   a_standby_entry: assert property (p_standby_entry) else $error("standby without halt");
   property p_halt_wake;
      halt_wr && wake |=> !standby [*2];
   endproperty
   a_halt_wake: assert property (p_halt_wake) else $error("standby entered with wake true");
   property p_wake;
      standby && wake |-> ##[1:2] !standby;
   endproperty
   a_wake: assert property (p_wake) else $error("standby not left on wake");
   property p_reset_vals;
      $rose(presetn) |-> key_scan_pins_out == 8'hff && !key_scan_pins_oe_n && !standby;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("port state wrong after reset");
   c_standby: cover property ($rose(standby));
   c_refused: cover property (pslverr);
   c_key_input: cover property ($rose(key_scan_pins_oe_n));
endmodule

// File: tb/mcs_core_tb_top.sv
// Purpose: self-checking bench for the core state block
// Assumes: apb with one wait state, 10 MHz pclk
// Notes: the bench drives two-way pins through the enables
module mcs_core_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import mcs_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   mcs_apb_req_type req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] kext = 8'h00;
   logic [7:0] kout;
   logic koe_n;
   logic s1_out;
   logic s1_oe_n;
   logic [3:0] kr = 4'h0;
   logic s0 = 1'b0;
   logic s1x = 1'b0;
   logic tz = 1'b0;
   logic [9:0] fw;
   logic standby;
   wire logic [7:0] kin = koe_n ? kext : kout;
   wire logic s1 = s1_oe_n ? s1x : s1_out;
   int bad_count = 0;
   int cmp_count = 0;
   logic [31:0] rq;
   logic err;
   logic [19:0] ctab [0:13] = '{20'h81818, 20'h81700, 20'hc3915, 20'h43c08, 20'h82808, 20'h88303, 20'h89006,
      20'h94013, 20'h6400c, 20'h95012, 20'hf6010, 20'he600f, 20'hf7010, 20'h87009};
   logic [15:0] stab [0:11] = '{16'h0000, 16'h4001, 16'h4031, 16'h4061, 16'h4050, 16'h4010, 16'h0851,
      16'h0800, 16'h0281, 16'h0481, 16'h0400, 16'h0080};
   always #50 pclk = ~pclk;
   mcs_core mcs_core_i (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .key_scan_pins_in(kin), .key_scan_pins_out(kout), .key_scan_pins_oe_n(koe_n),
      .key_return_pins(kr), .sense_zero_pin(s0), .sense_one_indicator_pin_in(s1),
      .sense_one_indicator_pin_out(s1_out), .sense_one_indicator_pin_oe_n(s1_oe_n),
      .timer_count_zero(tz), .fetch_word(fw), .standby(standby));
   // ==========================================
   // shared tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      req.penable <= 1'b1;
      // no cycle count assumed: only the watchdog ends a hung wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rq = prdata;
      err = pslverr;
      req <= '{1'b0, 1'b0, w, a, d};
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rq, e);
   endtask
   task automatic ex(input logic [3:0] op, input logic [3:0] opnd);
      wr(8'h14, {24'h0, opnd, op});
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================
   // scenarios
   task automatic t_reset_vals();
      rd(8'h00, 32'hff);
      rd(8'h04, 32'h0f);
      rd(8'h08, 32'h03);
      rd(8'h0c, 32'h26);
      rd(8'h20, 32'h0);
   endtask
   task automatic t_carry();
      kr <= 4'h6;
      // and with f first so every op starts from carry equal to bit 3
      foreach (ctab[i]) begin
         ex(MCS_OP_MOVI, ctab[i][19:16]);
         ex(MCS_OP_AND, 4'hf);
         ex(ctab[i][15:12], ctab[i][11:8]);
         rd(8'h10, {27'h0, ctab[i][4:0]});
      end
      kr <= 4'h0;
      wr(8'h18, 32'h2);
      wr(8'h1c, 32'h0);
      ex(MCS_OP_MOVI, 4'ha);
      ex(MCS_OP_STM, 4'h1);
      rd(8'h1c, 32'ha0);
      ex(MCS_OP_LDM, 4'h0);
      rd(8'h10, 32'h0);
   endtask
   task automatic t_test_status_op();
      wr(8'h0c, 32'h23);
      rd(8'h0c, 32'h23);
      foreach (stab[i]) begin
         kr <= stab[i][15:12];
         tz <= stab[i][11];
         s0 <= stab[i][10];
         s1x <= stab[i][9];
         // pins need the filter delay before the operation samples them
         repeat (4) @(posedge pclk);
         ex(MCS_OP_TEST_STATUS_OP, stab[i][7:4]);
         apb(1'b0, 8'h10, 32'h0);
         chk(32'(rq[5]), 32'(stab[i][0]));
      end
   endtask
   task automatic t_halt();
      kr <= 4'h1;
      repeat (4) @(posedge pclk);
      ex(MCS_OP_TEST_STATUS_OP, 4'h0);
      kr <= 4'h0;
      repeat (4) @(posedge pclk);
      ex(MCS_OP_HALT, 4'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(rq[6:5]), 32'h0);
      ex(MCS_OP_HALT, 4'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(rq[6:5]), 32'h2);
      // exec writes are dropped while in standby
      ex(MCS_OP_MOVI, 4'h9);
      tz <= 1'b1;
      repeat (3) @(posedge pclk);
      tz <= 1'b0;
      rd(8'h10, 32'h20);
      ex(MCS_OP_TEST_STATUS_OP, 4'h1);
      kr <= 4'h2;
      repeat (4) @(posedge pclk);
      ex(MCS_OP_HALT, 4'h0);
      apb(1'b0, 8'h10, 32'h0);
      chk(32'(rq[6:5]), 32'h1);
      kr <= 4'h0;
   endtask
   task automatic t_prog();
      wr(8'h30, 32'h5);
      wr(8'h34, 32'h2ab);
      wr(8'h24, 32'h5);
      rd(8'h28, 32'h2ab);
      chk(32'(fw), 32'h2ab);
      wr(8'h18, 32'h0);
      wr(8'h1c, 32'h5);
      rd(8'h2c, 32'h2ab);
      wr(8'h08, 32'hf3);
      rd(8'h08, 32'h33);
      wr(8'h1c, 32'h5a);
      rd(8'h20, 32'h35a);
      wr(8'h24, 32'h3ea);
      rd(8'h24, 32'h0);
      wr(8'h24, 32'h3e9);
      rd(8'h24, 32'h3e9);
      wr(8'h30, 32'h0);
      wr(8'h34, 32'h155);
      wr(8'h1c, 32'hff);
      rd(8'h2c, 32'h155);
      wr(8'h24, 32'h12);
      ex(MCS_OP_CALL, 4'h0);
      wr(8'h18, 32'hf);
      rd(8'h1c, 32'h12);
   endtask
   task automatic t_pairs();
      wr(8'h18, 32'h3);
      wr(8'h1c, 32'ha5);
      wr(8'h18, 32'h0);
      wr(8'h1c, 32'h77);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      wr(8'h18, 32'h3);
      rd(8'h1c, 32'ha5);
      wr(8'h18, 32'h0);
      rd(8'h1c, 32'h0);
      rd(8'h20, 32'h0);
   endtask
   task automatic t_keyscan();
      wr(8'h0c, 32'h24);
      kext <= 8'h3c;
      repeat (6) @(posedge pclk);
      rd(8'h00, 32'h3c);
      chk(32'(koe_n), 32'h1);
      wr(8'h00, 32'h81);
      rd(8'h00, 32'h3c);
      chk(32'(kout), 32'h81);
      wr(8'h0c, 32'h26);
      rd(8'h00, 32'h81);
      apb(1'b0, 8'h40, 32'h0);
      chk(32'(err), 32'h1);
      chk(rq, 32'h0);
   endtask
   // ==========================================
   // main sequence and watchdog
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset_vals();
      t_carry();
      t_test_status_op();
      t_halt();
      t_prog();
      t_pairs();
      t_keyscan();
      end_of_test();
   end
   initial begin
      #3000000;
      bad_count++;
      end_of_test();
   end
endmodule
bind mcs_core mcs_core_props mcs_core_props_i (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .key_scan_pins_out(key_scan_pins_out),
   .key_scan_pins_oe_n(key_scan_pins_oe_n), .key_return_pins(key_return_pins),
   .timer_count_zero(timer_count_zero), .standby(standby));
